// File: mcp_core.sv
// Core datapath: two-phase instruction cycle, fetch/execute pipeline,
// accumulator, status flags, return stack and core clock select.
// Program memory and file registers sit outside on the same clock and
// answer a read one clock after the request.
`timescale 1ns/1ns
`include "mcp_core_regs.svh"

// Operation
// - Instruction cycle is two core clock phases
// - Advance PC first, latch fetched word second
// - Execute previous word while fetching the next
// - Branches flush fetched word, cost two cycles
// - 8-bit add, subtract, shift, logic unit
// - Unaddressed accumulator plus file or literal operand
// - Single-operand source is accumulator or file
// - Flags update only when operation affects them
// - Subtract carries are inverted borrows
// - Program memory 2K words of 14 bits
// - Software selects fast or slow core clock
// - Flag-affecting writes to status keep flags
// - Add sets nibble carry from low nibble
// - Six-level 11-bit stack, calls and interrupts push
// - Call and goto load 11-bit target
module mcp_core
	import mcp_pkg::*;
#(
	parameter int FAST_DIV = `MCP_FAST_DIV,
	parameter int SLOW_DIV = `MCP_SLOW_DIV,
	parameter int STACK_DEPTH = `MCP_STACK_DEPTH
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic [10:0] pm_addr,
	output logic pm_rd,
	input wire logic [13:0] pm_rdata,
	output logic [6:0] fr_addr,
	output logic fr_re,
	output logic fr_we,
	output logic [7:0] fr_wdata,
	input wire logic [7:0] fr_rdata,
	input wire logic int_req,
	output logic int_ack,
	output logic first_phase,
	output logic second_phase
);
	// Refuse settings the counters and stack pointer cannot hold; a file operand
	// arrives two clocks after the first-phase tick, so a phase needs two clocks
	if (FAST_DIV < 2 || FAST_DIV > 2047 || SLOW_DIV < 2 || SLOW_DIV > 2047)
		$error("mcp_core: divider out of range");
	if (STACK_DEPTH < 1 || STACK_DEPTH > 8)
		$error("mcp_core: stack depth out of range");

	localparam logic [10:0] FAST_LIM = 11'(FAST_DIV - 1);
	localparam logic [10:0] SLOW_LIM = 11'(SLOW_DIV - 1);
	localparam logic [2:0] SP_TOP = 3'(STACK_DEPTH - 1);

	// Stack pointer step with wrap at the configured depth
	function automatic logic [2:0] sp_up(input logic [2:0] p);
		sp_up = (p == SP_TOP) ? 3'h0 : p + 3'h1;
	endfunction
	function automatic logic [2:0] sp_dn(input logic [2:0] p);
		sp_dn = (p == 3'h0) ? SP_TOP : p - 3'h1;
	endfunction

	logic [1:0] ctrl_q;
	logic [10:0] div_q;
	logic tick_q;
	mcp_phase_t phase_q;
	logic [10:0] pc_q;
	logic [13:0] ir_q;
	logic ir_valid_q;
	logic [7:0] w_q;
	logic [7:0] status_q;
	logic [7:0] file_q;
	logic fr_pend_q;
	logic [10:0] stack_q [STACK_DEPTH];
	logic [2:0] sp_q;

	// Control register writes and core tick divider
	always_ff @(posedge clk)
	begin
		if (reset)
			ctrl_q <= `MCP_CTRL_RESET;
		else if (reg_wr && reg_addr == `MCP_REG_CTRL)
			ctrl_q <= reg_wdata[1:0];
	end

	// One tick per selected oscillator period
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			div_q <= 11'h000;
			tick_q <= 1'b0;
		end
		else
		begin
			if (div_q >= (ctrl_q[`MCP_CTRL_SLOW] ? SLOW_LIM : FAST_LIM))
				div_q <= 11'h000;
			else
				div_q <= div_q + 11'h001;
			tick_q <= ctrl_q[`MCP_CTRL_RUN] &&
				div_q >= (ctrl_q[`MCP_CTRL_SLOW] ? SLOW_LIM : FAST_LIM);
		end
	end

	// Phase sequence: two ticks make one instruction cycle
	always_ff @(posedge clk)
	begin
		if (reset)
			phase_q <= PH_FIRST;
		else if (tick_q)
			phase_q <= (phase_q == PH_FIRST) ? PH_SECOND : PH_FIRST;
	end

	// Decode of the word in the execute stage
	mcp_class_t cls;
	logic [3:0] sub;
	logic [6:0] faddr;
	logic st_hit;
	logic single;
	logic ph1;
	logic ph2;
	logic exec;
	logic is_movwf;
	logic is_ret;
	logic is_retlw;
	logic branch;
	logic take_int;
	logic [7:0] opnd;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_dc;
	logic alu_z;
	logic upd_c;
	logic upd_dc;
	logic upd_z;
	logic wr_w;
	logic wr_file;
	logic [7:0] file_val;

	assign cls = mcp_class_t'(ir_q[13:12]);
	assign sub = ir_q[11:8];
	assign faddr = ir_q[6:0];
	assign st_hit = (faddr == `MCP_STATUS_FADDR);
	assign single = (ir_q[11:8] >= 4'(ALU_COM));
	assign ph1 = tick_q && phase_q == PH_FIRST;
	assign ph2 = tick_q && phase_q == PH_SECOND;
	assign exec = ph2 && ir_valid_q;
	assign is_movwf = cls == CLS_MISC && sub == `MCP_MISC_MOVWF;
	assign is_ret = cls == CLS_MISC && sub == `MCP_MISC_RET;
	assign is_retlw = cls == CLS_MISC && sub == `MCP_MISC_RETLW;
	assign branch = exec && (cls == CLS_JUMP || is_ret || is_retlw);
	assign take_int = ph2 && int_req && !branch;

	// Operand select: file or literal paired with the accumulator
	// At the shortest phase the file byte is still on the bus at execute
	always_comb
	begin
		if (cls == CLS_FILE)
			opnd = st_hit ? status_q : (fr_pend_q ? fr_rdata : file_q);
		else
			opnd = single ? w_q : ir_q[7:0];
	end

	mcp_alu u_alu (
		.op(ir_q[11:8]),
		.opnd(opnd),
		.acc(w_q),
		.cin(status_q[`MCP_FLAG_C]),
		.res(alu_res),
		.c_out(alu_c),
		.dc_out(alu_dc),
		.z_out(alu_z),
		.upd_c(upd_c),
		.upd_dc(upd_dc),
		.upd_z(upd_z)
	);

	assign wr_w = exec && ((cls == CLS_FILE && !ir_q[7]) || cls == CLS_LIT);
	assign wr_file = exec && ((cls == CLS_FILE && ir_q[7]) || is_movwf);
	assign file_val = is_movwf ? w_q : alu_res;

	// Program counter, fetch address and instruction register
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pc_q <= `MCP_RESET_VEC;
			pm_addr <= `MCP_RESET_VEC;
			pm_rd <= 1'b0;
			ir_q <= 14'h0000;
			ir_valid_q <= 1'b0;
		end
		else
		begin
			pm_rd <= ph1;
			if (ph1)
			begin
				pm_addr <= pc_q;
				pc_q <= pc_q + 11'h001;
			end
			if (ph2)
			begin
				ir_q <= pm_rdata;
				ir_valid_q <= !(branch || take_int);
				if (take_int)
					pc_q <= `MCP_INT_VEC;
				else if (exec && cls == CLS_JUMP)
					pc_q <= ir_q[10:0];
				else if (branch)
					pc_q <= stack_q[sp_dn(sp_q)];
			end
		end
	end

	// Return stack: calls and interrupts push, returns pop
	always_ff @(posedge clk)
	begin
		if (reset)
			sp_q <= 3'h0;
		else if (take_int || (exec && cls == CLS_JUMP && ir_q[11]))
		begin
			stack_q[sp_q] <= pm_addr;
			sp_q <= sp_up(sp_q);
		end
		else if (exec && (is_ret || is_retlw))
			sp_q <= sp_dn(sp_q);
	end

	// File register port: read in the first phase, write in the second
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			fr_addr <= 7'h00;
			fr_re <= 1'b0;
			fr_we <= 1'b0;
			fr_wdata <= 8'h00;
			fr_pend_q <= 1'b0;
			file_q <= 8'h00;
		end
		else
		begin
			fr_re <= ph1 && ir_valid_q && cls == CLS_FILE && !st_hit;
			fr_pend_q <= fr_re;
			if (fr_pend_q)
				file_q <= fr_rdata;
			if (ph1 && ir_valid_q)
				fr_addr <= faddr;
			fr_we <= wr_file && !st_hit;
			if (wr_file)
				fr_wdata <= file_val;
		end
	end

	// Accumulator
	always_ff @(posedge clk)
	begin
		if (reset)
			w_q <= 8'h00;
		else if (exec && is_retlw)
			w_q <= ir_q[7:0];
		else if (wr_w)
			w_q <= alu_res;
	end

	// Status: flag results win over a direct write of the same bits
	// Only file and literal results reach the flags; jumps and misc words never do, save a movwf to status
	always_ff @(posedge clk)
	begin
		if (reset)
			status_q <= `MCP_STATUS_RESET;
		else if (exec)
		begin
			if (wr_file && st_hit)
				status_q <= file_val;
			if (upd_c && (cls == CLS_FILE || cls == CLS_LIT))
				status_q[`MCP_FLAG_C] <= alu_c;
			if (upd_dc && (cls == CLS_FILE || cls == CLS_LIT))
				status_q[`MCP_FLAG_DC] <= alu_dc;
			if (upd_z && (cls == CLS_FILE || cls == CLS_LIT))
				status_q[`MCP_FLAG_Z] <= alu_z;
		end
	end

	// Interrupt acknowledge and phase outputs
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			int_ack <= 1'b0;
			first_phase <= 1'b0;
			second_phase <= 1'b0;
		end
		else
		begin
			int_ack <= take_int;
			first_phase <= phase_q == PH_FIRST;
			second_phase <= phase_q == PH_SECOND;
		end
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (reset)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`MCP_REG_CTRL: reg_rdata <= {14'h0000, ctrl_q};
				`MCP_REG_STATUS: reg_rdata <= {8'h00, status_q};
				`MCP_REG_ACC: reg_rdata <= {8'h00, w_q};
				`MCP_REG_PC: reg_rdata <= {5'h00, pc_q};
				`MCP_REG_SP: reg_rdata <= {13'h0000, sp_q};
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end
endmodule

// File: mcp_core_regs.svh
// Constants of the core datapath: offsets, bit positions, reset values, timing.
// Included by the core only; holds definitions only.
`ifndef MCP_CORE_REGS_SVH
`define MCP_CORE_REGS_SVH

// Clock and oscillator rates in kHz
`define MCP_CLK_KHZ 250000
`define MCP_FAST_OSC_KHZ 12000
`define MCP_SLOW_OSC_KHZ 128
// Core ticks: one per oscillator period, rounded down
`define MCP_FAST_DIV (`MCP_CLK_KHZ / `MCP_FAST_OSC_KHZ)
`define MCP_SLOW_DIV (`MCP_CLK_KHZ / `MCP_SLOW_OSC_KHZ)

// Software register indices
`define MCP_REG_CTRL 4'h0
`define MCP_REG_STATUS 4'h1
`define MCP_REG_ACC 4'h2
`define MCP_REG_PC 4'h3
`define MCP_REG_SP 4'h4
// Control register fields and reset value
`define MCP_CTRL_RUN 0
`define MCP_CTRL_SLOW 1
`define MCP_CTRL_RESET 2'h1

// Status register: file address and flag bits
`define MCP_STATUS_FADDR 7'h03
`define MCP_FLAG_C 0
`define MCP_FLAG_DC 1
`define MCP_FLAG_Z 2
`define MCP_STATUS_RESET 8'h00

// Program flow
`define MCP_RESET_VEC 11'h000
`define MCP_INT_VEC 11'h001
`define MCP_STACK_DEPTH 6

// Sub codes of the misc instruction class
`define MCP_MISC_NOP 4'h0
`define MCP_MISC_RET 4'h1
`define MCP_MISC_RETLW 4'h2
`define MCP_MISC_MOVWF 4'h3

`endif

// File: mcp_pkg.sv
// Types shared by the core and its arithmetic unit.
// Uses no macro from mcp_core_regs.svh.
package mcp_pkg;
	// Instruction class held in word bits 13:12
	typedef enum logic [1:0] {CLS_FILE, CLS_LIT, CLS_JUMP, CLS_MISC} mcp_class_t;
	// Arithmetic operation held in word bits 11:8
	typedef enum logic [3:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_MOV, ALU_COM,
		ALU_INC, ALU_DEC, ALU_RLC, ALU_RRC, ALU_SWAP, ALU_CLR} mcp_alu_op_t;
	// Half of the instruction cycle
	typedef enum logic {PH_FIRST, PH_SECOND} mcp_phase_t;
endpackage

// File: mcp_alu.sv
// 8-bit arithmetic unit of the core, purely combinational.
// Assumes the caller picks the operands and decides where results go.
`timescale 1ns/1ns
module mcp_alu
	import mcp_pkg::*;
(
	input wire logic [3:0] op,
	input wire logic [7:0] opnd,
	input wire logic [7:0] acc,
	input wire logic cin,
	output logic [7:0] res,
	output logic c_out,
	output logic dc_out,
	output logic z_out,
	output logic upd_c,
	output logic upd_dc,
	output logic upd_z
);
	logic [8:0] sum;
	logic [4:0] low;

	// Result and flag effects per operation
	always_comb
	begin
		sum = 9'h000;
		low = 5'h00;
		res = opnd;
		c_out = cin;
		dc_out = 1'b0;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		upd_z = 1'b0;
		case (op)
			ALU_ADD:
			begin
				sum = {1'b0, opnd} + {1'b0, acc};
				low = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
				res = sum[7:0];
				c_out = sum[8];
				dc_out = low[4];
				{upd_c, upd_dc, upd_z} = 3'h7;
			end
			ALU_SUB:
			begin
				// Add the complement: carry out is high when no borrow occurs
				sum = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
				low = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
				res = sum[7:0];
				c_out = sum[8];
				dc_out = low[4];
				{upd_c, upd_dc, upd_z} = 3'h7;
			end
			ALU_AND:
			begin
				res = opnd & acc;
				upd_z = 1'b1;
			end
			ALU_OR:
			begin
				res = opnd | acc;
				upd_z = 1'b1;
			end
			ALU_XOR:
			begin
				res = opnd ^ acc;
				upd_z = 1'b1;
			end
			ALU_MOV: upd_z = 1'b1;
			ALU_COM:
			begin
				res = ~opnd;
				upd_z = 1'b1;
			end
			ALU_INC:
			begin
				res = opnd + 8'h01;
				upd_z = 1'b1;
			end
			ALU_DEC:
			begin
				res = opnd - 8'h01;
				upd_z = 1'b1;
			end
			ALU_RLC:
			begin
				res = {opnd[6:0], cin};
				c_out = opnd[7];
				upd_c = 1'b1;
			end
			ALU_RRC:
			begin
				res = {cin, opnd[7:1]};
				c_out = opnd[0];
				upd_c = 1'b1;
			end
			ALU_SWAP: res = {opnd[3:0], opnd[7:4]};
			ALU_CLR:
			begin
				res = 8'h00;
				upd_z = 1'b1;
			end
			default: res = opnd; // Unused codes pass the operand, no flags
		endcase
		z_out = (res == 8'h00);
	end
endmodule

// File: mcp_core_monitor.sv
// Checker of the core ports: phase order, fetch strobes, file access.
// Bound into the core; one clock, synchronous reset.
`timescale 1ns/1ns
module mcp_core_monitor
#(
	parameter int FAST_DIV = 20,
	parameter int SLOW_DIV = 1953
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [10:0] pm_addr,
	input wire logic pm_rd,
	input wire logic [6:0] fr_addr,
	input wire logic fr_re,
	input wire logic fr_we,
	input wire logic first_phase,
	input wire logic second_phase
);
	logic [15:0] gap_q;
	// Cycles since the last fetch, zero before the first one
	always_ff @(posedge clk)
	begin
		if (reset)
			gap_q <= 16'h0000;
		else if (pm_rd)
			gap_q <= 16'h0001;
		else if (gap_q != 16'h0000 && gap_q != 16'hFFFF)
			gap_q <= gap_q + 16'h0001;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// Phases never overlap and follow each other
	a_phase_excl:
		assert property (!(first_phase && second_phase))
		else $error("both phases high");
	a_phase_next:
		assert property (!$past(reset) && $fell(first_phase) |-> second_phase)
		else $error("second phase missing");
	// Fetch strobe width, spacing and start address
	a_fetch_pulse:
		assert property (pm_rd |=> !pm_rd)
		else $error("fetch strobe too long");
	a_fetch_space:
		assert property (pm_rd && gap_q != 16'h0000 |-> gap_q >= 16'(2 * FAST_DIV))
		else $error("fetches too close");
	a_reset_vector:
		assert property (pm_rd && gap_q == 16'h0000 |-> pm_addr == 11'h000)
		else $error("first fetch not at zero");
	// No file access before the first fetch, none to status, short writes
	a_no_early:
		assert property (gap_q == 16'h0000 |-> !fr_re && !fr_we)
		else $error("file access before first fetch");
	a_status_local:
		assert property (fr_re || fr_we |-> fr_addr != 7'h03)
		else $error("status reached the file bus");
	a_write_pulse:
		assert property (fr_we |=> !fr_we)
		else $error("file write too long");
	c_fetch: cover property (pm_rd);
	c_file_read: cover property (fr_re);
	c_file_write: cover property (fr_we);
endmodule

bind mcp_core mcp_core_monitor #(.FAST_DIV(FAST_DIV), .SLOW_DIV(SLOW_DIV)) u_mon (.clk(clk),
	.reset(reset), .pm_addr(pm_addr), .pm_rd(pm_rd), .fr_addr(fr_addr), .fr_re(fr_re),
	.fr_we(fr_we), .first_phase(first_phase), .second_phase(second_phase));

// File: mcp_mem_model.sv
// Program memory and file registers facing the core.
// Bench loads both by hierarchy; answers one clock after a request.
`timescale 1ns/1ns
module mcp_mem_model
(
	input wire logic clk,
	input wire logic [10:0] pm_addr,
	input wire logic pm_rd,
	output logic [13:0] pm_rdata,
	input wire logic [6:0] fr_addr,
	input wire logic fr_re,
	input wire logic fr_we,
	input wire logic [7:0] fr_wdata,
	output logic [7:0] fr_rdata
);
	logic [13:0] rom [2048];
	logic [7:0] ram [128];
	initial pm_rdata = 14'h0000;
	initial fr_rdata = 8'h00;
	// Word held until the next fetch; file data valid one cycle, else scrambled
	always @(posedge clk)
	begin
		if (pm_rd)
			pm_rdata <= rom[pm_addr];
		fr_rdata <= fr_re ? ram[fr_addr] : ~fr_rdata;
		if (fr_we)
			ram[fr_addr] <= fr_wdata;
	end
endmodule

// File: tb_mcp_core.sv
// Bench of the core: one short program per operation, then clock select.
// Memory model on the far side; reset held 16 cycles.
`timescale 1ns/1ns
module tb_mcp_core;
	localparam int FD = 2;
	localparam int SD = 4;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_d = 1'b0;
	logic int_req = 1'b0;
	logic int_ack;
	logic [15:0] reg_rdata;
	logic [10:0] pm_addr;
	logic [13:0] pm_rdata;
	logic [6:0] fr_addr;
	logic [7:0] fr_wdata, fr_rdata;
	logic pm_rd, fr_re, fr_we;
	logic [15:0] q_fw[$], q_rd[$];
	int n_fail = 0;
	int n_compared = 0;
	mcp_core #(.FAST_DIV(FD), .SLOW_DIV(SD)) DUT (.clk(clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
		.fr_addr(fr_addr), .fr_re(fr_re), .fr_we(fr_we), .fr_wdata(fr_wdata),
		.fr_rdata(fr_rdata), .int_req(int_req), .int_ack(int_ack), .first_phase(),
		.second_phase());
	mcp_mem_model u_mem (.clk(clk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
		.fr_addr(fr_addr), .fr_re(fr_re), .fr_we(fr_we), .fr_wdata(fr_wdata),
		.fr_rdata(fr_rdata));
	initial forever #2 clk = ~clk;

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		q_rd.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	// Result and flags: {update z dc c, z, dc, c, result}
	function automatic logic [13:0] alu(input int o, input logic [7:0] x,
		input logic [7:0] w, input logic ci);
		logic [8:0] r;
		logic [4:0] d4;
		case (o)
			0: r = {1'b0, x} + {1'b0, w};
			1: r = {1'b0, x} - {1'b0, w};
			2: r = {1'b0, x & w};
			3: r = {1'b0, x | w};
			4: r = {1'b0, x ^ w};
			5: r = {1'b0, x};
			6: r = {1'b0, ~x};
			7: r = {1'b0, x + 8'h01};
			8: r = {1'b0, x - 8'h01};
			9: r = {x, ci};
			10: r = {x[0], ci, x[7:1]};
			11: r = {1'b0, x[3:0], x[7:4]};
			default: r = 9'h000;
		endcase
		d4 = {1'b0, x[3:0]} + (o == 1 ? -{1'b0, w[3:0]} : {1'b0, w[3:0]});
		return {o < 2 ? 3'b111 : (o == 9 || o == 10) ? 3'b001 : o == 11 ? 3'b000 : 3'b100,
			r[7:0] == 8'h00, d4[4] ^ (o == 1), r[8] ^ (o == 1), r[7:0]};
	endfunction

	// Load, literal op, store, file op, then branch over a trap into a loop
	task automatic run_op(input int o);
		logic [7:0] a, b, c, w;
		logic [2:0] st;
		logic [13:0] f;
		int k;
		a = 8'($urandom);
		b = 8'($urandom);
		c = 8'($urandom);
		reset <= 1'b1;
		u_mem.rom[0] = {2'b01, 4'h5, a};
		u_mem.rom[1] = {2'b01, 4'(o), b};
		u_mem.rom[2] = {6'h33, 1'b0, 7'h20};
		u_mem.rom[3] = {2'b00, 4'(o), 1'b1, 7'h21};
		u_mem.rom[4] = 14'h2006;
		u_mem.rom[5] = {6'h33, 1'b0, 7'h22};
		u_mem.rom[6] = 14'h2006;
		u_mem.ram[33] = c;
		st = 3'b000;
		f = alu(5, a, 8'h00, 1'b0);
		w = f[7:0];
		st = (st & ~f[13:11]) | (f[10:8] & f[13:11]);
		f = alu(o, o > 5 ? w : b, w, st[0]);
		w = f[7:0];
		st = (st & ~f[13:11]) | (f[10:8] & f[13:11]);
		q_fw.push_back({1'b0, 7'h20, w});
		f = alu(o, c, w, st[0]);
		st = (st & ~f[13:11]) | (f[10:8] & f[13:11]);
		q_fw.push_back({1'b0, 7'h21, f[7:0]});
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		for (k = 0; k < 400 && pm_addr !== 11'h006; k++)
			@(negedge clk);
		if (k == 400)
			n_fail++;
		rd(4'h2, {8'h00, w});
		rd(4'h1, {13'h0000, st});
		cmp(16'(q_fw.size()), 16'h0000);
		$display("op %0d done", o);
	endtask

	// Call into a returning literal, then an interrupt taken from the idle loop
	task automatic run_call();
		logic [7:0] x;
		int k;
		x = 8'($urandom);
		reset <= 1'b1;
		u_mem.rom[0] = 14'h2803;
		u_mem.rom[1] = 14'h3320;
		u_mem.rom[2] = 14'h2002;
		u_mem.rom[3] = {6'h32, x};
		u_mem.rom[4] = 14'h3322;
		q_fw.push_back({1'b0, 7'h20, x});
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		for (k = 0; k < 400 && pm_addr !== 11'h002; k++)
			@(negedge clk);
		if (k == 400)
			n_fail++;
		rd(4'h2, {8'h00, x});
		rd(4'h4, 16'h0000);
		q_fw.push_back({1'b0, 7'h20, x});
		@(posedge clk);
		int_req <= 1'b1;
		for (k = 0; k < 400 && int_ack !== 1'b1; k++)
			@(posedge clk);
		if (k == 400)
			n_fail++;
		int_req <= 1'b0;
		repeat (20) @(posedge clk);
		rd(4'h4, 16'h0001);
		cmp(16'(q_fw.size()), 16'h0000);
		$display("call and interrupt done");
	endtask

	// Skip to a fetch, then count cycles to the next one
	task automatic gap(input int e);
		int n;
		n = 0;
		repeat (2)
		begin
			@(negedge clk);
			for (n = 1; n < 99 && pm_rd !== 1'b1; n++)
				@(negedge clk);
		end
		cmp(16'(n), 16'(e));
	endtask

	// Each result takes the oldest note of its kind
	always @(posedge clk)
	begin
		rd_d <= reg_rd;
		if (rd_d)
			cmp(reg_rdata, q_rd.size() > 0 ? q_rd.pop_front() : 16'hFFFF);
		if (fr_we)
			cmp({1'b0, fr_addr, fr_wdata}, q_fw.size() > 0 ? q_fw.pop_front() : 16'hFFFF);
	end

	initial
	begin
		void'($urandom(42));
		for (int o = 0; o < 13; o++)
			run_op(o);
		run_call();
		gap(2 * FD);
		wr(4'h0, 16'h0003);
		gap(2 * SD);
		rd(4'h0, 16'h0003);
		rd(4'hF, 16'h0000);
		wr(4'h0, 16'h0001);
		gap(2 * FD);
		$display("clock select done");
		close_out();
	end

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		close_out();
	end
endmodule
